// file: hw/fcr_defines.svh
// Bit positions, reset values, command codes and dummy counts of the flash configuration registers.
`ifndef FCR_DEFINES_SVH
`define FCR_DEFINES_SVH

`define FCR_FN_RSVD_BIT       0
`define FCR_FN_SIDE_BIT       1
`define FCR_FN_PROG_PAUSE_BIT 2
`define FCR_FN_ERASE_PAUSE_BIT 3
`define FCR_FN_LOCK_LSB       4
`define FCR_FN_OTP_MASK       8'hf2
`define FCR_FN_RESET          8'h00

`define FCR_RP_DRIVE_MSB      7
`define FCR_RP_DRIVE_LSB      5
`define FCR_RP_DUMMY_MSB      4
`define FCR_RP_DUMMY_LSB      3
`define FCR_RP_WRAP_BIT       2
`define FCR_RP_BURST_MSB      1
`define FCR_RP_BURST_LSB      0
`define FCR_RP_RESET          8'he0

`define FCR_CMD_SET_READ_PARAMS 8'hc0
`define FCR_CMD_FUNC_REG_WRITE  8'h42
`define FCR_CMD_NORMAL_READ     8'h03
`define FCR_CMD_FAST_READ       8'h0b
`define FCR_CMD_FAST_READ_DTR   8'h0d
`define FCR_CMD_DUAL_OUT_READ   8'h3b
`define FCR_CMD_QUAD_OUT_READ   8'h6b
`define FCR_CMD_DUAL_IO_READ    8'hbb
`define FCR_CMD_DUAL_IO_DTR     8'hbd
`define FCR_CMD_QUAD_IO_READ    8'heb
`define FCR_CMD_QUAD_IO_DTR     8'hed

`define FCR_DUMMY_SDR_FIXED   4'h8
`define FCR_DUMMY_DTR_FIXED   4'h4
`define FCR_DUMMY_NONE        4'h0

`define FCR_LINK_FRAME_BITS   5'h10
`define FCR_LINK_CMD_LAST     5'h07
`define FCR_LINK_DATA_LAST    5'h0f

`endif

// file: hw/fcr_pkg.sv
// Types shared by the flash configuration register block.
package fcr_pkg;

   typedef logic [7:0]  fcr_byte_t;
   typedef logic [3:0]  fcr_dummy_t;
   typedef logic [23:0] fcr_addr_t;

   typedef struct packed {
      logic [7:0] shift;
      fcr_byte_t  cmdHold;
      fcr_byte_t  dataHold;
      logic       frameToggle;
   } fcr_link_s;

   typedef struct packed {
      logic       toggleSync1;
      logic       toggleSync2;
      logic       toggleSeen;
      fcr_byte_t  functionReg;
      fcr_byte_t  readParam;
      fcr_dummy_t dummyCycles;
      fcr_addr_t  nextAddr;
      logic [3:0] driveEighths;
      logic       driveReserved;
      logic [6:0] wrapBytes;
      logic       writeAccept;
   } fcr_sys_s;

endpackage

// file: hw/fcr_link_rx.sv
// Serial link receiver that captures register write commands on the link clock.
`timescale 1ns/100ps
`include "fcr_defines.svh"
module fcr_link_rx (
   input  wire logic              sckLink,
   input  wire logic              csLink_b,
   input  wire logic              mosiLink,
   input  wire logic              rst_b,
   output fcr_pkg::fcr_byte_t     cmdHold,
   output fcr_pkg::fcr_byte_t     dataHold,
   output logic                   frameToggle
);
   import fcr_pkg::*;

   fcr_link_s  link_r;
   fcr_link_s  link_nxt;
   logic [4:0] bitCount_r;
   logic [7:0] shiftIn;

   // The link clock stops between frames, so the frame's own select clears the bit count.
   always_ff @(posedge sckLink or posedge csLink_b) begin
      if (csLink_b) begin
         bitCount_r <= 5'h00;
      end else if (bitCount_r != `FCR_LINK_FRAME_BITS) begin
         bitCount_r <= bitCount_r + 5'h01;
      end
   end

   assign shiftIn = {link_r.shift[6:0], mosiLink};

   always_comb begin
      link_nxt       = link_r;
      link_nxt.shift = shiftIn;
      if (bitCount_r == `FCR_LINK_CMD_LAST) begin
         link_nxt.cmdHold = shiftIn;
      end
      // The data hold word stays stable until the next toggle, the command hold word until the eighth bit of the next frame; both are many system cycles away.
      if (bitCount_r == `FCR_LINK_DATA_LAST) begin
         if (link_r.cmdHold == `FCR_CMD_SET_READ_PARAMS ||
             link_r.cmdHold == `FCR_CMD_FUNC_REG_WRITE) begin
            link_nxt.dataHold    = shiftIn;
            link_nxt.frameToggle = ~link_r.frameToggle;
         end
      end
   end

   always_ff @(posedge sckLink or negedge rst_b) begin
      if (!rst_b) begin
         link_r <= '0;
      end else begin
         link_r <= link_nxt;
      end
   end

   assign cmdHold     = link_r.cmdHold;
   assign dataHold    = link_r.dataHold;
   assign frameToggle = link_r.frameToggle;

endmodule

// file: hw/fcr_top.sv
// Function and read parameter registers of a serial flash, with their decoded controls.
// Operation
// - Side select bit chooses top or bottom, sticky.
// - Side select and row lock bits only go from zero to one.
// - Program paused flag set on suspend, cleared on resume.
// - Erase paused flag set on suspend, cleared on resume.
// - Locked information row refuses program requests.
// - Read parameters: drive, dummy, wrap, burst fields.
// - Set read params command loads all eight bits.
// - Burst code selects 8, 16, 32, 64 bytes.
// - Wrap enable picks burst or whole array wrap.
// - Single, dual, quad output reads use eight dummies.
// - Quad I/O and QPI fast read: 6,4,8,10.
// - Quad I/O DTR and QPI DTR: 3,2,4,5.
// - Dual I/O read uses four or eight dummies.
// - Dual I/O DTR uses two or four dummies.
// - SPI single lane DTR read uses four dummies.
// - ID, parameter, row reads follow fast read.
// - Drive code maps to strength, two codes reserved.
// - Function register write needs write enable latch.
`timescale 1ns/100ps
`include "fcr_defines.svh"
module fcr_top (
   input  wire logic              clk_sys,
   input  wire logic              rst_b,
   input  wire logic              clkEn,
   input  wire logic              sckLink,
   input  wire logic              csLink_b,
   input  wire logic              mosiLink,
   input  wire logic              write_enable_latch,
   input  wire logic              programSuspendPulse,
   input  wire logic              programResumePulse,
   input  wire logic              eraseSuspendPulse,
   input  wire logic              eraseResumePulse,
   input  wire logic              infoRowProgReq,
   input  wire logic [1:0]        infoRowSel,
   input  fcr_pkg::fcr_byte_t     readCmd,
   input  wire logic              qpiMode,
   input  wire logic              auxFastRead,
   input  fcr_pkg::fcr_addr_t     curAddr,
   output fcr_pkg::fcr_byte_t     otp_function_control,
   output fcr_pkg::fcr_byte_t     read_parameter_control,
   output logic                   protect_area_side_select,
   output logic                   program_paused_flag,
   output logic                   erase_paused_flag,
   output logic                   info_row0_lock,
   output logic                   info_row1_lock,
   output logic                   info_row2_lock,
   output logic                   info_row3_lock,
   output logic                   drive_code_bit2,
   output logic                   drive_code_bit1,
   output logic                   drive_code_bit0,
   output logic [3:0]             driveEighths,
   output logic                   driveReserved,
   output logic                   wrapEnable,
   output logic [6:0]             wrapBytes,
   output fcr_pkg::fcr_dummy_t    dummyCycles,
   output fcr_pkg::fcr_addr_t     nextAddr,
   output logic                   infoRowProgGrant,
   output logic                   infoRowProgRefuse,
   output logic                   writeAccept
);
   import fcr_pkg::*;

   fcr_sys_s  sys_r;
   fcr_sys_s  sys_nxt;
   fcr_byte_t linkCmd;
   fcr_byte_t linkData;
   logic      linkToggle;
   logic      frameEvent;
   logic [3:0] rowLocks;
   logic [1:0] dummySel;
   logic [1:0] burstCode;
   logic [5:0] burstMask;
   fcr_addr_t  addrInc;

   fcr_link_rx u_link_rx (
      .sckLink     (sckLink),
      .csLink_b    (csLink_b),
      .mosiLink    (mosiLink),
      .rst_b       (rst_b),
      .cmdHold     (linkCmd),
      .dataHold    (linkData),
      .frameToggle (linkToggle)
   );

   function automatic fcr_dummy_t dummyFor(
      input fcr_byte_t  cmd,
      input logic [1:0] sel,
      input logic       qpi,
      input logic       aux
   );
      fcr_dummy_t qioSdr;
      fcr_dummy_t qioDtr;
      fcr_dummy_t result;
      qioSdr = 4'h6;
      qioDtr = 4'h3;
      result = `FCR_DUMMY_NONE;
      unique case (sel)
         2'h0: begin
            qioSdr = 4'h6;
            qioDtr = 4'h3;
         end
         2'h1: begin
            qioSdr = 4'h4;
            qioDtr = 4'h2;
         end
         2'h2: begin
            qioSdr = 4'h8;
            qioDtr = 4'h4;
         end
         2'h3: begin
            qioSdr = 4'ha;
            qioDtr = 4'h5;
         end
      endcase
      if (aux) begin
         result = qpi ? qioSdr : `FCR_DUMMY_SDR_FIXED;
      end else begin
         case (cmd)
            `FCR_CMD_NORMAL_READ: result = `FCR_DUMMY_NONE;
            `FCR_CMD_FAST_READ: result = qpi ? qioSdr : `FCR_DUMMY_SDR_FIXED;
            `FCR_CMD_DUAL_OUT_READ: result = `FCR_DUMMY_SDR_FIXED;
            `FCR_CMD_QUAD_OUT_READ: result = `FCR_DUMMY_SDR_FIXED;
            `FCR_CMD_QUAD_IO_READ: result = qioSdr;
            `FCR_CMD_QUAD_IO_DTR: result = qioDtr;
            `FCR_CMD_FAST_READ_DTR: result = qpi ? qioDtr : `FCR_DUMMY_DTR_FIXED;
            `FCR_CMD_DUAL_IO_READ: result = sel[1] ? 4'h8 : 4'h4;
            `FCR_CMD_DUAL_IO_DTR: result = sel[1] ? 4'h4 : 4'h2;
            default: result = `FCR_DUMMY_NONE;
         endcase
      end
      return result;
   endfunction

   // Only the second synchroniser stage and the seen copy feed the edge detector.
   assign frameEvent = sys_r.toggleSync2 ^ sys_r.toggleSeen;

   assign rowLocks  = sys_r.functionReg[`FCR_FN_LOCK_LSB +: 4];
   assign dummySel  = sys_r.readParam[`FCR_RP_DUMMY_MSB:`FCR_RP_DUMMY_LSB];
   assign burstCode = sys_r.readParam[`FCR_RP_BURST_MSB:`FCR_RP_BURST_LSB];
   assign addrInc   = curAddr + 24'h000001;

   always_comb begin
      unique case (burstCode)
         2'h0: burstMask = 6'h07;
         2'h1: burstMask = 6'h0f;
         2'h2: burstMask = 6'h1f;
         2'h3: burstMask = 6'h3f;
      endcase
   end

   always_comb begin
      sys_nxt             = sys_r;
      sys_nxt.toggleSync1 = linkToggle;
      sys_nxt.toggleSync2 = sys_r.toggleSync1;
      sys_nxt.toggleSeen  = sys_r.toggleSync2;
      sys_nxt.writeAccept = 1'b0;

      if (frameEvent && linkCmd == `FCR_CMD_SET_READ_PARAMS) begin
         sys_nxt.readParam = linkData;
      end
      // A write without the latch set is dropped; the latch itself is cleared elsewhere.
      if (frameEvent && linkCmd == `FCR_CMD_FUNC_REG_WRITE && write_enable_latch) begin
         sys_nxt.functionReg = sys_r.functionReg | (linkData & `FCR_FN_OTP_MASK);
         sys_nxt.writeAccept = 1'b1;
      end

      // Set wins over clear when suspend and resume land together.
      if (programSuspendPulse) begin
         sys_nxt.functionReg[`FCR_FN_PROG_PAUSE_BIT] = 1'b1;
      end else if (programResumePulse) begin
         sys_nxt.functionReg[`FCR_FN_PROG_PAUSE_BIT] = 1'b0;
      end
      if (eraseSuspendPulse) begin
         sys_nxt.functionReg[`FCR_FN_ERASE_PAUSE_BIT] = 1'b1;
      end else if (eraseResumePulse) begin
         sys_nxt.functionReg[`FCR_FN_ERASE_PAUSE_BIT] = 1'b0;
      end
      sys_nxt.functionReg[`FCR_FN_RSVD_BIT] = 1'b0;

      sys_nxt.dummyCycles = dummyFor(readCmd, dummySel, qpiMode, auxFastRead);

      if (sys_r.readParam[`FCR_RP_WRAP_BIT]) begin
         sys_nxt.nextAddr = {curAddr[23:6], (curAddr[5:0] & ~burstMask) |
                             (addrInc[5:0] & burstMask)};
      end else begin
         sys_nxt.nextAddr = addrInc;
      end
      sys_nxt.wrapBytes = {1'b0, burstMask} + 7'h01;

      sys_nxt.driveReserved = 1'b0;
      unique case (sys_r.readParam[`FCR_RP_DRIVE_MSB:`FCR_RP_DRIVE_LSB])
         3'h1: sys_nxt.driveEighths = 4'h1;
         3'h2: sys_nxt.driveEighths = 4'h2;
         3'h3: sys_nxt.driveEighths = 4'h3;
         3'h5: sys_nxt.driveEighths = 4'h6;
         3'h6: sys_nxt.driveEighths = 4'h8;
         3'h7: sys_nxt.driveEighths = 4'h4;
         default: begin
            sys_nxt.driveEighths  = 4'h0;
            sys_nxt.driveReserved = 1'b1;
         end
      endcase
   end

   // Reset models power-up, so the one-time bits come back as shipped as well.
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         sys_r              <= '0;
         sys_r.functionReg  <= `FCR_FN_RESET;
         sys_r.readParam    <= `FCR_RP_RESET;
         sys_r.driveEighths <= 4'h4;
         sys_r.wrapBytes    <= 7'h08;
      end else if (clkEn) begin
         sys_r <= sys_nxt;
      end
   end

   // The refusal path is combinational so a program request sees the lock in its own cycle.
   assign infoRowProgRefuse = infoRowProgReq & rowLocks[infoRowSel];
   assign infoRowProgGrant  = infoRowProgReq & ~rowLocks[infoRowSel];

   assign otp_function_control     = sys_r.functionReg;
   assign read_parameter_control   = sys_r.readParam;
   assign protect_area_side_select = sys_r.functionReg[`FCR_FN_SIDE_BIT];
   assign program_paused_flag      = sys_r.functionReg[`FCR_FN_PROG_PAUSE_BIT];
   assign erase_paused_flag        = sys_r.functionReg[`FCR_FN_ERASE_PAUSE_BIT];
   assign info_row0_lock           = rowLocks[0];
   assign info_row1_lock           = rowLocks[1];
   assign info_row2_lock           = rowLocks[2];
   assign info_row3_lock           = rowLocks[3];
   assign drive_code_bit2          = sys_r.readParam[`FCR_RP_DRIVE_MSB];
   assign drive_code_bit1          = sys_r.readParam[`FCR_RP_DRIVE_MSB - 1];
   assign drive_code_bit0          = sys_r.readParam[`FCR_RP_DRIVE_LSB];
   assign driveEighths             = sys_r.driveEighths;
   assign driveReserved            = sys_r.driveReserved;
   assign wrapEnable               = sys_r.readParam[`FCR_RP_WRAP_BIT];
   assign wrapBytes                = sys_r.wrapBytes;
   assign dummyCycles              = sys_r.dummyCycles;
   assign nextAddr                 = sys_r.nextAddr;
   assign writeAccept              = sys_r.writeAccept;

endmodule

// file: verif/fcr_host.sv
// Host side of the serial link that shifts command frames in.
`timescale 1ns/100ps
module fcr_host (
   output logic sckLink,
   output logic csLink_b,
   output logic mosiLink
);
   initial begin
      sckLink = 1'b0;
      csLink_b = 1'b0;
      mosiLink = 1'b0;
      // A real rising edge on select clears the bit count before the first frame.
      #1 csLink_b = 1'b1;
   end
   // The clock runs only in a frame; idle data is inverted so no stale bit looks valid.
   task automatic send(input logic [7:0] op, input logic [7:0] dat);
      logic [15:0] f;
      f = {op, dat};
      csLink_b = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         mosiLink = f[i];
         #80 sckLink = 1'b1;
         #80 sckLink = 1'b0;
      end
      #80 csLink_b = 1'b1;
      mosiLink = ~f[0];
   endtask
endmodule

// file: verif/fcr_props.sv
// Concurrent checks on the flash configuration register ports.
`timescale 1ns/100ps
module fcr_props (
   input wire logic          clk_sys,
   input wire logic          rst_b,
   input wire logic          clkEn,
   input wire logic          write_enable_latch,
   input wire logic          programSuspendPulse,
   input wire logic          eraseSuspendPulse,
   input wire logic          eraseResumePulse,
   input wire logic          infoRowProgReq,
   input wire logic [1:0]    infoRowSel,
   input fcr_pkg::fcr_byte_t readCmd,
   input wire logic          qpiMode,
   input fcr_pkg::fcr_byte_t otp_function_control,
   input fcr_pkg::fcr_byte_t read_parameter_control,
   input wire logic          protect_area_side_select,
   input wire logic          program_paused_flag,
   input wire logic          erase_paused_flag,
   input wire logic          infoRowProgRefuse,
   input wire logic          infoRowProgGrant,
   input wire logic          driveReserved,
   input wire logic [6:0]    wrapBytes,
   input fcr_pkg::fcr_dummy_t dummyCycles,
   input wire logic          writeAccept
);
   import fcr_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   a_side_sticky: assert property (protect_area_side_select |=> protect_area_side_select)
      else $error("side select cleared");
   a_otp_keep: assert property (
      ($past(otp_function_control) & ~otp_function_control & 8'hf2) == 8'h00)
      else $error("otp bit cleared");
   a_rsvd_zero: assert property (otp_function_control[0] == 1'b0)
      else $error("reserved bit set");
   a_prog_set: assert property (clkEn && programSuspendPulse |=> program_paused_flag)
      else $error("program flag not set");
   a_erase_clr: assert property (
      clkEn && eraseResumePulse && !eraseSuspendPulse |=> !erase_paused_flag)
      else $error("erase flag not cleared");
   a_row_guard: assert property (
      infoRowProgReq |-> infoRowProgRefuse == otp_function_control[4 + infoRowSel]
      && infoRowProgGrant == !infoRowProgRefuse)
      else $error("row guard wrong");
   a_wrap_size: assert property (
      clkEn |=> wrapBytes == (7'h08 << $past(read_parameter_control[1:0])))
      else $error("wrap size wrong");
   a_drive_rsvd: assert property (
      clkEn |=> driveReserved == ($past(read_parameter_control[6:5]) == 2'b00))
      else $error("drive reserved wrong");
   a_wel_gate: assert property (writeAccept |-> $past(write_enable_latch))
      else $error("write without enable");
   a_dtr_fixed: assert property (
      clkEn && !qpiMode && readCmd == 8'h0d |=> dummyCycles == 4'h4)
      else $error("dtr dummy wrong");
   c_write: cover property (writeAccept);
   c_refuse: cover property (infoRowProgReq && infoRowProgRefuse);
   c_pause: cover property ($rose(program_paused_flag));
endmodule
bind fcr_top fcr_props fcr_props_inst (.*);

// file: verif/tb_top.sv
// Self-checking bench for the flash configuration registers.
`timescale 1ns/100ps
module tb_top;
   import fcr_pkg::*;
   logic       clk_sys, rst_b, clkEn, sckLink, csLink_b, mosiLink, write_enable_latch;
   logic       programSuspendPulse, programResumePulse, eraseSuspendPulse, eraseResumePulse;
   logic       infoRowProgReq, qpiMode, auxFastRead, protect_area_side_select;
   logic       program_paused_flag, erase_paused_flag, info_row0_lock, info_row1_lock;
   logic       info_row2_lock, info_row3_lock, drive_code_bit2, drive_code_bit1;
   logic       drive_code_bit0, driveReserved, wrapEnable, infoRowProgGrant;
   logic       infoRowProgRefuse, writeAccept;
   logic [1:0] infoRowSel;
   logic [3:0] driveEighths;
   logic [6:0] wrapBytes;
   fcr_byte_t  readCmd, otp_function_control, read_parameter_control;
   fcr_dummy_t dummyCycles;
   fcr_addr_t  curAddr, nextAddr;
   int         n_fail, n_tests, cyc, nAcc;
   logic [2:0] drv [4] = '{3'h0, 3'h4, 3'h1, 3'h7};
   logic [3:0] eig [4] = '{4'h0, 4'h0, 4'h1, 4'h4};
   fcr_dummy_t qio [4] = '{4'h6, 4'h4, 4'h8, 4'ha};
   fcr_dummy_t qdt [4] = '{4'h3, 4'h2, 4'h4, 4'h5};
   fcr_top fcr_top_inst (.*);
   fcr_host fcr_host_inst (.*);
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic wrap_up();
      $display("Checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         wrap_up();
      end
   end
   // Accept pulses stand one cycle, so they are counted at the falling edge where they are settled.
   always @(negedge clk_sys) begin
      if (writeAccept === 1'b1) nAcc++;
   end
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic wr(input fcr_byte_t op, input fcr_byte_t d);
      fcr_host_inst.send(op, d);
      tick(6);
   endtask
   task automatic dum(input fcr_byte_t c, input logic q, input logic a, input fcr_dummy_t e);
      readCmd = c;
      qpiMode = q;
      auxFastRead = a;
      tick(1);
      chk(dummyCycles, e);
   endtask
   task automatic pulse(input logic [3:0] p);
      {programSuspendPulse, programResumePulse, eraseSuspendPulse, eraseResumePulse} = p;
      tick(1);
      {programSuspendPulse, programResumePulse, eraseSuspendPulse, eraseResumePulse} = 4'h0;
   endtask
   initial begin
      n_fail = 0;
      n_tests = 0;
      cyc = 0;
      nAcc = 0;
      rst_b = 1'b1;
      clkEn = 1'b1;
      write_enable_latch = 1'b0;
      {programSuspendPulse, programResumePulse, eraseSuspendPulse, eraseResumePulse} = 4'h0;
      infoRowProgReq = 1'b0;
      infoRowSel = 2'h0;
      readCmd = 8'h03;
      qpiMode = 1'b0;
      auxFastRead = 1'b0;
      curAddr = 24'h00007f;
      // A real falling edge on reset is needed so the link receiver clears at start.
      #1 rst_b = 1'b0;
      tick(10);
      rst_b = 1'b1;
      tick(2);
      chk(otp_function_control, 8'h00);
      chk(read_parameter_control, 8'he0);
      chk(nextAddr, 24'h000080);
      for (int s = 0; s < 4; s++) begin
         wr(8'hc0, {drv[s], 2'(s), 1'b1, 2'(s)});
         chk(read_parameter_control, {drv[s], 2'(s), 1'b1, 2'(s)});
         chk({drive_code_bit2, drive_code_bit1, drive_code_bit0, wrapEnable}, {drv[s], 1'b1});
         chk(wrapBytes, 7'h08 << s);
         chk(driveReserved, s < 2);
         chk(driveEighths, eig[s]);
         dum(8'heb, 1'b0, 1'b0, qio[s]);
         dum(8'h0b, 1'b1, 1'b0, qio[s]);
         dum(8'hed, 1'b0, 1'b0, qdt[s]);
         dum(8'h0d, 1'b1, 1'b0, qdt[s]);
         dum(8'hbb, 1'b0, 1'b0, s < 2 ? 4'h4 : 4'h8);
         dum(8'hbd, 1'b0, 1'b0, s < 2 ? 4'h2 : 4'h4);
         dum(8'h0d, 1'b0, 1'b0, 4'h4);
         dum(8'h3b, 1'b0, 1'b0, 4'h8);
         dum(8'h6b, 1'b0, 1'b0, 4'h8);
         dum(8'h0b, 1'b0, 1'b0, 4'h8);
         dum(8'h0b, 1'b0, 1'b1, 4'h8);
         dum(8'h0b, 1'b1, 1'b1, qio[s]);
      end
      chk(nextAddr, 24'h000040);
      wr(8'h42, 8'hff);
      chk(otp_function_control, 8'h00);
      write_enable_latch = 1'b1;
      infoRowProgReq = 1'b1;
      #1 chk({infoRowProgGrant, infoRowProgRefuse}, 2'b10);
      wr(8'h42, 8'h13);
      chk(otp_function_control, 8'h12);
      chk({infoRowProgGrant, infoRowProgRefuse}, 2'b01);
      infoRowSel = 2'h3;
      #1 chk({infoRowProgGrant, infoRowProgRefuse}, 2'b10);
      wr(8'h42, 8'h00);
      chk(otp_function_control, 8'h12);
      wr(8'h42, 8'hff);
      chk(otp_function_control, 8'hf2);
      chk({info_row3_lock, info_row2_lock, info_row1_lock, info_row0_lock, erase_paused_flag,
           program_paused_flag, protect_area_side_select}, 7'h79);
      chk({infoRowProgGrant, infoRowProgRefuse}, 2'b01);
      infoRowProgReq = 1'b0;
      clkEn = 1'b0;
      pulse(4'h8);
      clkEn = 1'b1;
      chk(program_paused_flag, 1'b0);
      pulse(4'h8);
      chk(otp_function_control, 8'hf6);
      pulse(4'h6);
      chk(otp_function_control, 8'hfa);
      pulse(4'h1);
      chk(otp_function_control, 8'hf2);
      pulse(4'hc);
      chk(otp_function_control, 8'hf6);
      pulse(4'h4);
      chk(otp_function_control, 8'hf2);
      chk(nAcc, 3);
      rst_b = 1'b0;
      tick(10);
      rst_b = 1'b1;
      tick(1);
      chk(read_parameter_control, 8'he0);
      wrap_up();
   end
endmodule
